//--- src/fwp_flash_protect.sv
// fwp_flash_protect: write protection and status register one of a serial
// nor flash, with an spi slave front end on the link clock.
// assumes: host drives sck/cs_n/si; array engine reports array_op_done.
`timescale 1ns/1ps
`default_nettype none
module fwp_flash_protect
    import fwp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so_out,
    output logic so_oe,
    input wire logic wp_n,
    input wire logic hw_reset_n,
    input wire logic supply_ok,
    input wire logic protect_scheme_select,
    input wire logic array_op_done,
    output logic array_op_start,
    output fwp_kind_e array_op_kind,
    output logic [23:0] array_op_addr,
    output logic [7:0] status_register_one
);
    ////////////////////////////////////////////////////////////////////////
    // functions
    function automatic logic [LOCK_AW-1:0] lock_idx(input logic [23:0] a);
        logic [7:0] blk;
        logic [8:0] sec;
        blk = a[23:16];
        sec = {5'h00, a[15:12]};
        if (blk == BLOCK_FIRST) begin
            lock_idx = sec;
        end else if (blk == BLOCK_LAST) begin
            lock_idx = LOCK_TOP_BASE + sec;
        end else begin
            lock_idx = LOCK_MID_BASE + {1'b0, blk} - 9'h001;
        end
    endfunction

    // protected block count doubles per step: 4,8,...,128,256
    function automatic logic bp_protects(input logic [23:0] a,
                                         input logic [2:0] bp,
                                         input logic tb, input logic cmp);
        logic [8:0] n;
        logic [8:0] blk;
        logic hit;
        n = (bp == 3'h0) ? 9'h000 : 9'(BP_BASE_BLOCKS << bp);
        blk = {1'b0, a[23:16]};
        hit = tb ? (blk < n) : (blk >= BLOCK_SPAN - n);
        bp_protects = hit ^ cmp;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // link clock domain: frame capture
    logic in_frame;
    logic [5:0] bit_cnt;
    logic [5:0] next_bit_cnt;
    logic [31:0] shreg;
    logic [31:0] next_shreg;
    logic [7:0] op_l;
    logic [7:0] dat_l;
    logic [23:0] addr_l;
    logic [8:0] stat_meta;
    logic [8:0] stat_sync;
    logic rd_active;
    logic quiet;

    assign next_shreg = {shreg[30:0], si};

    always_comb begin
        if (!in_frame) begin
            next_bit_cnt = CNT_ONE;
        end else if (bit_cnt == CNT_MAX) begin
            next_bit_cnt = bit_cnt;
        end else begin
            next_bit_cnt = bit_cnt + CNT_ONE;
        end
    end

    // cs_n high clears the frame flag; the count itself is kept so the
    // system side can read the frame length after sck has stopped
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            in_frame <= 1'b0;
        end else begin
            in_frame <= 1'b1;
        end
    end

    always_ff @(posedge sck) begin
        bit_cnt <= next_bit_cnt;
        shreg <= next_shreg;
    end

    always_ff @(posedge sck) begin
        if (next_bit_cnt == FRAME_OP_BITS) begin
            op_l <= next_shreg[7:0];
        end
        if (next_bit_cnt == FRAME_DAT_BITS) begin
            dat_l <= next_shreg[7:0];
        end
        if (next_bit_cnt == FRAME_ADDR_BITS) begin
            addr_l <= next_shreg[23:0];
        end
    end

    // status bits are independent levels, so a plain two-flop path is safe
    always_ff @(posedge sck) begin
        stat_meta <= {quiet, status_register_one};
        stat_sync <= stat_meta;
    end

    assign rd_active = in_frame && (bit_cnt >= FRAME_OP_BITS)
        && (op_l == OP_READ_STATUS_ONE) && !stat_sync[SR_QUIET];

    // the status byte repeats until the bit count saturates at 63, after which bit 0 is held
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            so_oe <= 1'b0;
            so_out <= 1'b0;
        end else begin
            so_oe <= rd_active;
            so_out <= rd_active & stat_sync[BIT_TOP - bit_cnt[2:0]];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_m1;
    logic [PIN_N-1:0] pin_m2;
    logic [PIN_N-1:0] pin_m3;
    logic [PIN_N-1:0] pin_lvl;

    assign pin_raw = {wp_n, supply_ok, hw_reset_n, cs_n};

    always_ff @(posedge mclk) begin
        pin_m1 <= pin_raw;
        pin_m2 <= pin_m1;
        pin_m3 <= pin_m2;
    end

    genvar gi;
    generate
        for (gi = 0; gi < PIN_N; gi++) begin : g_pin
            always_ff @(posedge mclk) begin
                if (rst) begin
                    pin_lvl[gi] <= (gi == PIN_CS) || (gi == PIN_WP);
                end else if (pin_m2[gi] == pin_m3[gi]) begin
                    pin_lvl[gi] <= pin_m3[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // frame hand-over; link registers are stable while cs_n stays high
    logic frame_end;
    logic pend1;
    logic cmd_go;
    logic [7:0] f_op;
    logic [7:0] f_dat;
    logic [23:0] f_addr;
    logic [5:0] f_cnt;

    assign frame_end = pin_m2[PIN_CS] & pin_m3[PIN_CS] & ~pin_lvl[PIN_CS];

    always_ff @(posedge mclk) begin
        if (rst) begin
            pend1 <= 1'b0;
            cmd_go <= 1'b0;
        end else begin
            pend1 <= frame_end;
            cmd_go <= pend1;
        end
    end

    always_ff @(posedge mclk) begin
        if (frame_end) begin
            f_op <= op_l;
            f_dat <= dat_l;
            f_addr <= addr_l;
            f_cnt <= bit_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decode
    fwp_state_e state;
    logic [TMR_W-1:0] tmr;
    logic write_enable_latch, vol_wen, rst_armed, busy, lock_bit, sr_commit;
    logic [2:0] bp_field;
    logic top_bottom_select, complement_protect, status_register_protect;
    logic [7:0] wsr_data;
    logic [7:0] sr_src;
    logic accept, region_prot, sr_write_ok, is_array_op, por_hold;
    logic do_write_enable_cmd, do_write_disable_cmd, do_vwen, do_wsr, do_array, do_unlock;
    logic do_pd, do_release, do_sw_rst;

    assign busy = (state == ST_WSR) || (state == ST_ARRAY);
    assign quiet = (state == ST_POR) || (state == ST_PDOWN);

    always_comb begin
        // busy, power-down and reset states all fall outside idle
        accept = cmd_go && (f_cnt >= FRAME_OP_BITS)
            && (state == ST_IDLE);
        is_array_op = (f_op == OP_PAGE_PROGRAM)
            || (f_op == OP_SECTOR_ERASE) || (f_op == OP_BLOCK_ERASE);
        region_prot = bp_protects(f_addr, bp_field, top_bottom_select,
            complement_protect)
            | (protect_scheme_select & lock_bit);
        sr_write_ok = (write_enable_latch | vol_wen)
            & ~(status_register_protect & ~pin_lvl[PIN_WP]);
        do_write_enable_cmd = accept && (f_op == OP_WRITE_ENABLE);
        do_write_disable_cmd = accept && (f_op == OP_WRITE_DISABLE);
        do_vwen = accept && (f_op == OP_VOL_WRITE_ENABLE);
        do_wsr = accept && (f_op == OP_WRITE_STATUS)
            && (f_cnt >= FRAME_DAT_BITS) && sr_write_ok;
        do_array = accept && is_array_op && (f_cnt >= FRAME_ADDR_BITS)
            && write_enable_latch && !region_prot;
        do_unlock = accept && (f_op == OP_UNLOCK)
            && (f_cnt >= FRAME_ADDR_BITS);
        do_pd = accept && (f_op == OP_POWER_DOWN);
        do_release = cmd_go && (f_cnt >= FRAME_OP_BITS)
            && (state == ST_PDOWN) && (f_op == OP_RELEASE_PD);
        do_sw_rst = accept && (f_op == OP_RESET) && rst_armed;
        por_hold = ~pin_lvl[PIN_SUPPLY]
            | ~pin_lvl[PIN_HWRST] | do_sw_rst;
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge mclk) begin
        if (rst || por_hold) begin
            state <= ST_POR;
            tmr <= POR_CYCLES;
        end else begin
            case (state)
                ST_POR: begin
                    if (tmr == '0) begin
                        state <= ST_IDLE;
                    end else begin
                        tmr <= tmr - TMR_ONE;
                    end
                end
                ST_IDLE: begin
                    if (do_wsr && !vol_wen) begin
                        state <= ST_WSR;
                        tmr <= WSR_CYCLES - TMR_ONE;
                    end else if (do_array) begin
                        state <= ST_ARRAY;
                    end else if (do_pd) begin
                        state <= ST_PDOWN;
                    end
                end
                ST_WSR: begin
                    if (tmr == '0) begin
                        state <= ST_IDLE;
                    end else begin
                        tmr <= tmr - TMR_ONE;
                    end
                end
                ST_ARRAY: begin
                    if (array_op_done) begin
                        state <= ST_IDLE;
                    end
                end
                ST_PDOWN: begin
                    if (do_release) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_POR;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || por_hold || (state == ST_POR)) begin
            write_enable_latch <= 1'b0;
        end else if (do_write_enable_cmd) begin
            write_enable_latch <= 1'b1;
        end else if (do_write_disable_cmd || do_wsr || do_array) begin
            write_enable_latch <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || por_hold || (state == ST_POR)) begin
            vol_wen <= 1'b0;
        end else if (accept) begin
            vol_wen <= do_vwen;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || por_hold) begin
            rst_armed <= 1'b0;
        end else if (accept) begin
            rst_armed <= (f_op == OP_RESET_ENABLE);
        end
    end

    // a volatile write lands at once; a normal one when its busy time ends
    assign sr_src = do_wsr ? f_dat : wsr_data;
    assign sr_commit = (do_wsr && vol_wen)
        || ((state == ST_WSR) && (tmr == '0));

    // nonvolatile fields survive a power-on restart; only rst clears them
    always_ff @(posedge mclk) begin
        if (rst) begin
            wsr_data <= SR_RESET;
            bp_field <= SR_RESET[SR_BP_HI:SR_BP_LO];
            top_bottom_select <= SR_RESET[SR_TB];
            complement_protect <= SR_RESET[SR_CMP];
            status_register_protect <= SR_RESET[SR_SRP];
        end else begin
            if (do_wsr) begin
                wsr_data <= f_dat;
            end
            if (sr_commit) begin
                bp_field <= sr_src[SR_BP_HI:SR_BP_LO];
                top_bottom_select <= sr_src[SR_TB];
                complement_protect <= sr_src[SR_CMP];
                status_register_protect <= sr_src[SR_SRP];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lock bits and outputs
    fwp_lock_mem u_lock (
        .clk(mclk),
        .fill(state == ST_POR),
        .clr_en(do_unlock),
        .clr_idx(lock_idx(f_addr)),
        .rd_idx(lock_idx(f_addr)),
        .rd_bit(lock_bit)
    );

    always_ff @(posedge mclk) begin
        if (rst) begin
            array_op_start <= 1'b0;
            array_op_kind <= FWP_KIND_PROGRAM;
            array_op_addr <= '0;
        end else begin
            array_op_start <= do_array && !por_hold;
            if (do_array) begin
                array_op_addr <= f_addr;
                case (f_op)
                    OP_SECTOR_ERASE: array_op_kind <= FWP_KIND_SECTOR_ERASE;
                    OP_BLOCK_ERASE: array_op_kind <= FWP_KIND_BLOCK_ERASE;
                    default: array_op_kind <= FWP_KIND_PROGRAM;
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            status_register_one <= SR_RESET;
        end else begin
            status_register_one <= {status_register_protect,
                complement_protect, top_bottom_select, bp_field,
                write_enable_latch, busy};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    localparam int WSR_DLY = 200;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_wsr_begin;
        (state == ST_IDLE) ##1 (state == ST_WSR);
    endsequence

    sequence s_locked_try;
        accept && is_array_op && (f_cnt >= FRAME_ADDR_BITS) && region_prot;
    endsequence

    a_supply_hold: assert property (!pin_lvl[PIN_SUPPLY] |=>
        (state == ST_POR) && !array_op_start && !busy)
        else $error("supply low did not hold reset");
    a_hwrst_restart: assert property ($fell(pin_lvl[PIN_HWRST]) |=>
        (state == ST_POR) && (tmr == POR_CYCLES))
        else $error("hardware reset did not restart power-on");
    a_pdown_ignore: assert property ((state == ST_PDOWN) && cmd_go
        && (f_op != OP_RELEASE_PD) && pin_lvl[PIN_SUPPLY]
        && pin_lvl[PIN_HWRST] |=> (state == ST_PDOWN) && $stable(write_enable_latch))
        else $error("power-down obeyed a command");
    a_locked_drop: assert property (s_locked_try |=>
        !array_op_start && !busy ##1 !array_op_start)
        else $error("protected region was programmed or erased");
    a_busy_ignore: assert property (busy && cmd_go &&
        (f_op == OP_WRITE_ENABLE) |=> $stable(write_enable_latch))
        else $error("instruction taken while busy");
    a_wsr_guard: assert property (cmd_go && (state == ST_IDLE)
        && (f_op == OP_WRITE_STATUS) && status_register_protect
        && !pin_lvl[PIN_WP] |=> (state != ST_WSR)
        && $stable(bp_field) ##1 $stable(bp_field))
        else $error("status written while hardware protected");
    a_wel_set: assert property (do_write_enable_cmd && !por_hold |=> write_enable_latch
        ##1 status_register_one[SR_WEL])
        else $error("write enable did not set latch");
    a_wel_clear: assert property (do_array && !por_hold |=>
        !write_enable_latch && busy && array_op_start)
        else $error("array start did not clear latch or set busy");
    a_wsr_time: assert property (s_wsr_begin |->
        ##[WSR_DLY:WSR_DLY] (state == ST_IDLE) || por_hold)
        else $error("status write busy time wrong");
    a_factory_zero: assert property (@(posedge mclk) disable iff (1'b0)
        rst |=> (bp_field == '0) && !status_register_protect
        && !complement_protect && !top_bottom_select && !write_enable_latch)
        else $error("status bits not zero after reset");
endmodule
`default_nettype wire

//--- src/fwp_pkg.sv
// fwp_pkg: opcodes, status-register layout, lock geometry, timing, types.
// assumes: 200 MHz system clock; SPI link clock supplied by the host.
package fwp_pkg;
    localparam logic [7:0] OP_READ_STATUS_ONE = 8'h05;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_VOL_WRITE_ENABLE = 8'h50;
    localparam logic [7:0] OP_UNLOCK = 8'h39;
    localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
    localparam logic [7:0] OP_RESET = 8'h99;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
    localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
    localparam logic [7:0] OP_RELEASE_PD = 8'hab;

    // link frame bit counts
    localparam logic [5:0] CNT_MAX = 6'h3f;
    localparam logic [5:0] CNT_ONE = 6'h01;
    localparam logic [5:0] FRAME_OP_BITS = 6'h08;
    localparam logic [5:0] FRAME_DAT_BITS = 6'h10;
    localparam logic [5:0] FRAME_ADDR_BITS = 6'h20;
    localparam logic [2:0] BIT_TOP = 3'h7;

    // status register one layout
    localparam int SR_BUSY = 0;
    localparam int SR_WEL = 1;
    localparam int SR_BP_LO = 2;
    localparam int SR_BP_HI = 4;
    localparam int SR_TB = 5;
    localparam int SR_CMP = 6;
    localparam int SR_SRP = 7;
    localparam int SR_QUIET = 8;
    localparam logic [7:0] SR_RESET = 8'h00;

    // individual lock bits: 16 bottom sectors, 16 top sectors, 254 blocks
    localparam int LOCK_COUNT = 286;
    localparam int LOCK_AW = 9;
    localparam logic [8:0] LOCK_TOP_BASE = 9'h010;
    localparam logic [8:0] LOCK_MID_BASE = 9'h020;
    localparam logic [7:0] BLOCK_FIRST = 8'h00;
    localparam logic [7:0] BLOCK_LAST = 8'hff;
    localparam logic [8:0] BLOCK_SPAN = 9'h100;
    localparam logic [8:0] BP_BASE_BLOCKS = 9'h002;

    // timing
    localparam int CLK_NS = 5;
    localparam int POR_DELAY_NS = 100;
    localparam int STATUS_WRITE_NS = 1000;
    localparam int TMR_W = 8;
    localparam logic [TMR_W-1:0] POR_CYCLES =
        TMR_W'((POR_DELAY_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TMR_W-1:0] WSR_CYCLES =
        TMR_W'(STATUS_WRITE_NS / CLK_NS);
    localparam logic [TMR_W-1:0] TMR_ONE = 8'h01;

    // synchronised pins
    localparam int PIN_CS = 0;
    localparam int PIN_HWRST = 1;
    localparam int PIN_SUPPLY = 2;
    localparam int PIN_WP = 3;
    localparam int PIN_N = 4;

    typedef enum logic [1:0] {
        FWP_KIND_PROGRAM = 2'b00,
        FWP_KIND_SECTOR_ERASE = 2'b01,
        FWP_KIND_BLOCK_ERASE = 2'b10
    } fwp_kind_e;

    typedef enum logic [2:0] {
        ST_POR = 3'b000,
        ST_IDLE = 3'b001,
        ST_WSR = 3'b010,
        ST_ARRAY = 3'b011,
        ST_PDOWN = 3'b100
    } fwp_state_e;
endpackage

//--- src/fwp_lock_mem.sv
// fwp_lock_mem: individual lock bits, bulk set, single clear, registered read.
// assumes: fill is held for at least one cycle before first use.
`timescale 1ns/1ps
`default_nettype none
module fwp_lock_mem
    import fwp_pkg::*;
(
    input wire logic clk,
    input wire logic fill,
    input wire logic clr_en,
    input wire logic [LOCK_AW-1:0] clr_idx,
    input wire logic [LOCK_AW-1:0] rd_idx,
    output logic rd_bit
);
    logic [LOCK_COUNT-1:0] bits;

    always_ff @(posedge clk) begin
        if (fill) begin
            bits <= '1;
        end else if (clr_en && (int'(clr_idx) < LOCK_COUNT)) begin
            bits[clr_idx] <= 1'b0;
        end
    end

    // out-of-range index reads as locked so it can never open a region
    always_ff @(posedge clk) begin
        if (int'(rd_idx) < LOCK_COUNT) begin
            rd_bit <= bits[rd_idx];
        end else begin
            rd_bit <= 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- verif/fwp_host.sv
// fwp_host: behavioural spi host that shifts frames into the flash block.
// assumes: mode 0, link clock stands low outside frames, 64 ns period.
`timescale 1ns/1ps
`default_nettype none
module fwp_host (
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so_out
);
    logic [7:0] rd;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        rd = 8'h00;
    end
    // frame bits are left-aligned in d, msb first; opcodes come from the
    // caller, which only issues the documented codes
    task automatic xfer(input logic [31:0] d, input int n);
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            si = d[31-i];
            #32 sck = 1'b1;
            rd = {rd[6:0], so_out};
            #32 sck = 1'b0;
        end
        #32 cs_n = 1'b1;
        // released line shows the inverse so a stale bit is never trusted
        si = ~si;
        // deselect must outlast the system-side synchroniser before a new frame
        #64;
    endtask
endmodule
`default_nettype wire

//--- verif/fwp_flash_protect_test.sv
// fwp_flash_protect_test: self-checking bench for the flash protect block.
// assumes: fwp_host drives the link; bench plays the array engine.
`timescale 1ns/1ps
`default_nettype none
module fwp_flash_protect_test;
    import fwp_pkg::*;
    `define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin \
        fail_count++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
    logic mclk, rst, wp_n, hw_reset_n, supply_ok, pss, so_out, so_oe;
    logic sck, cs_n, si, array_op_start, busy_seen, oe_seen;
    logic [9:0] dly;
    logic [7:0] sr;
    logic [23:0] addr;
    fwp_kind_e kind;
    int fail_count, total_checks, starts, cyc;
    fwp_flash_protect i_dut (.mclk(mclk), .rst(rst), .sck(sck), .cs_n(cs_n),
        .si(si), .so_out(so_out), .so_oe(so_oe), .wp_n(wp_n),
        .hw_reset_n(hw_reset_n), .supply_ok(supply_ok),
        .protect_scheme_select(pss), .array_op_done(dly[9]),
        .array_op_start(array_op_start), .array_op_kind(kind),
        .array_op_addr(addr), .status_register_one(sr));
    fwp_host h (.sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // array engine finishes ten cycles after each accepted start
    always @(posedge mclk) begin
        dly <= #1 {dly[8:0], array_op_start};
        if (array_op_start === 1'b1) starts <= starts + 1;
        if (sr[0] === 1'b1) busy_seen <= 1'b1;
        if (so_oe === 1'b1) oe_seen <= 1'b1;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            results();
        end
    end
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic cmd(input logic [7:0] op);
        h.xfer({op, 24'h000000}, 8);
        wt(30);
    endtask
    task automatic wr_sr(input logic [7:0] d);
        h.xfer({OP_WRITE_STATUS, d, 16'h0000}, 16);
        wt(30);
    endtask
    task automatic adr(input logic [7:0] op, input logic [23:0] a);
        h.xfer({op, a}, 32);
        wt(40);
    endtask
    task automatic t_reset;
        `CHK("status", 8'h00, sr)
        h.xfer({OP_READ_STATUS_ONE, 24'h0}, 16);
        `CHK("read", 8'h00, h.rd)
        `CHK("oe", 2'b10, {oe_seen, so_oe})
    endtask
    task automatic t_latch;
        cmd(OP_WRITE_ENABLE);
        `CHK("wel set", 1'b1, sr[1])
        cmd(OP_WRITE_DISABLE);
        `CHK("wel clr", 1'b0, sr[1])
    endtask
    task automatic t_locks;
        pss = 1'b1;
        cmd(OP_WRITE_ENABLE);
        adr(OP_PAGE_PROGRAM, 24'h123400);
        `CHK("locked", 0, starts)
        `CHK("wel kept", 1'b1, sr[1])
        adr(OP_UNLOCK, 24'h120000);
        adr(OP_PAGE_PROGRAM, 24'h123400);
        `CHK("unlocked", 1, starts)
        `CHK("addr", 24'h123400, addr)
        `CHK("kind", FWP_KIND_PROGRAM, kind)
        `CHK("busy seen", 1'b1, busy_seen)
        `CHK("ready", 2'b00, sr[1:0])
        cmd(OP_WRITE_ENABLE);
        adr(OP_BLOCK_ERASE, 24'h12ffff);
        `CHK("erase", 2, starts)
        `CHK("erase kind", FWP_KIND_BLOCK_ERASE, kind)
        pss = 1'b0;
    endtask
    task automatic t_status;
        cmd(OP_WRITE_ENABLE);
        wr_sr(8'h9c);
        `CHK("wsr busy", 1'b1, sr[0])
        cmd(OP_WRITE_ENABLE);
        wt(200);
        `CHK("fields", 8'h9c, sr)
        cmd(OP_WRITE_ENABLE);
        adr(OP_SECTOR_ERASE, 24'h000000);
        `CHK("bp all", 2, starts)
        wp_n = 1'b0;
        wr_sr(8'h00);
        wt(200);
        `CHK("wp lock", 8'h9e, sr)
        wp_n = 1'b1;
        wr_sr(8'h60);
        wt(200);
        `CHK("wp free", 8'h60, sr)
        h.xfer({OP_READ_STATUS_ONE, 24'h0}, 16);
        `CHK("read sr", 8'h60, h.rd)
    endtask
    task automatic t_power;
        cmd(OP_POWER_DOWN);
        cmd(OP_WRITE_ENABLE);
        `CHK("pd ignore", 1'b0, sr[1])
        cmd(OP_RELEASE_PD);
        cmd(OP_WRITE_ENABLE);
        supply_ok = 1'b0;
        wt(20);
        supply_ok = 1'b1;
        wt(40);
        `CHK("supply", 1'b0, sr[1])
        cmd(OP_WRITE_ENABLE);
        hw_reset_n = 1'b0;
        wt(20);
        hw_reset_n = 1'b1;
        wt(40);
        `CHK("hw reset", 1'b0, sr[1])
        cmd(OP_WRITE_ENABLE);
        cmd(OP_RESET_ENABLE);
        cmd(OP_RESET);
        `CHK("sw reset", 1'b0, sr[1])
        cmd(OP_VOL_WRITE_ENABLE);
        wr_sr(8'h0c);
        `CHK("vol sr", 8'h0c, sr)
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        {rst, wp_n, hw_reset_n, supply_ok} = 4'hf;
        {pss, busy_seen, oe_seen, dly, starts, cyc, fail_count,
            total_checks} = '0;
        wt(10);
        rst = 1'b0;
        wt(40);
        t_reset();
        t_latch();
        t_locks();
        t_status();
        t_power();
        results();
    end
endmodule
`default_nettype wire
